// [hdl/odc_top.sv]
// Register side of the orientation detect and range configuration logic.
// Assumes the serial interface delivers one-cycle read/write strobes and
// that the angle logic supplies a raw orientation as steady levels.
`timescale 1ns/1ns
`include "odc_consts.svh"
//
// Contract
// - Identity register is read-only and returns a fixed build-time value.
// - Range field picks 2, 4 or 8 g; code 11 reserved; resets to 00.
// - Change flag sets on first detection after activation and any change.
// - Reading the status register clears change flag and interrupt source.
// - Lockout flag in bit 6 reads 1 when lockout angle exceeded.
// - Orientation code: 00 up, 01 down, 10 right, 11 left.
// - Back/front flag in bit 0: 0 front, 1 back.
// - After reset back/front, code and lockout all read zero.
// - Orientation result is frozen while any axis exceeds 1.25 g.
// - Reported orientation keeps updating while the change flag is set.
// - Mode 0 decrements, mode 1 clears the counter on lapse; default 1.
// - Enable bit turns detection off at 0, on at 1; resets 0.
// - Debounce count sets steps a new orientation must persist.
// - Wake/sleep transitions either way reset the debounce counter.
// - Time step follows data rate and oversampling mode with caps.
// - Interrupt source follows change flag while interrupt is enabled.
module odc_top
   import odc_pkg::*;
#(
   // Arbitrary identity value
   parameter logic [7:0] DEVICE_ID     = 8'hA7,
   parameter int         STEP_BASE_CYC = `ODC_STEP_BASE_CYC
)
(
   input  wire logic            CLK_I,
   input  wire logic            RST_N_I,
   input  wire odc_reg_req_type REG_REQ_I,
   output logic [7:0]           REG_RDATA_O,
   input  wire odc_orient_type  RAW_ORIENT_I,
   input  wire logic            OVER_RANGE_I,
   input  wire logic            ACTIVE_I,
   input  wire logic            SLEEP_I,
   input  wire logic [2:0]      RATE_SEL_I,
   input  wire odc_osmode_type  OS_MODE_I,
   input  wire logic            IRQ_ENABLE_I,
   output logic [1:0]           RANGE_SELECT_O,
   output odc_orient_type       ORIENT_O,
   output logic                 ORIENT_IRQ_SOURCE_O
);
   odc_state_type  state_q;
   odc_state_type  state_d;
   odc_orient_type orient_q;
   odc_orient_type orient_d;
   logic [1:0]     range_select_q;
   logic           counter_mode_q;
   logic           detect_enable_q;
   logic [7:0]     debounce_value_q;
   logic           change_flag_q;
   logic           change_flag_d;
   logic           irq_source_q;
   logic           sleep_q;
   logic           sleep_edge;
   logic           step_tick;
   logic           step_live;
   logic           accept;
   logic           differ;
   logic           run;
   logic           first_seen;
   logic           set_change;
   logic           status_read;
   logic           filter_clear;
   logic [7:0]     read_value;

   // Decodes a write strobe aimed at one register
   function automatic logic wr_hit(input odc_reg_req_type req,
                                   input logic [7:0]      addr);
      wr_hit = req.wr && (req.addr == addr);
   endfunction

   // Register writes

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         range_select_q <= `ODC_RANGE_RST;
      else if (wr_hit(REG_REQ_I, `ODC_ADDR_RANGE))
         range_select_q <= REG_REQ_I.wdata[`ODC_RANGE_HI:0];
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         counter_mode_q  <= `ODC_MODE_RST;
         detect_enable_q <= `ODC_ENABLE_RST;
      end
      else if (wr_hit(REG_REQ_I, `ODC_ADDR_CONFIG))
      begin
         counter_mode_q  <= REG_REQ_I.wdata[`ODC_CFG_MODE_BIT];
         detect_enable_q <= REG_REQ_I.wdata[`ODC_CFG_ENABLE_BIT];
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         debounce_value_q <= `ODC_DEBOUNCE_RST;
      else if (wr_hit(REG_REQ_I, `ODC_ADDR_DEBOUNCE))
         debounce_value_q <= REG_REQ_I.wdata;
   end

   // The range code drives the data path; reserved 11 is stored as written
   // so software sees what it wrote, the data path decides what it means.
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         RANGE_SELECT_O <= `ODC_RANGE_RST;
      else
         RANGE_SELECT_O <= range_select_q;
   end

   // Wake/sleep edge detection

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         sleep_q <= 1'b0;
      else
         sleep_q <= SLEEP_I;
   end

   assign sleep_edge = (sleep_q != SLEEP_I);

   // Detection is live only when active and enabled
   assign run = ACTIVE_I && detect_enable_q;

   // Counter and step timer restart on any wake/sleep change or when idle
   assign filter_clear = sleep_edge || !run;

   odc_step_timer #(
      .BASE_CYC (STEP_BASE_CYC)
   ) u_step_timer (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .clear_i (filter_clear),
      .rate_i  (RATE_SEL_I),
      .mode_i  (OS_MODE_I),
      .tick_o  (step_tick)
   );

   // Steps are swallowed under high g so both counter and result hold
   assign step_live = step_tick && !OVER_RANGE_I;

   assign differ = (state_q == ODC_ST_TRACK) && (RAW_ORIENT_I != orient_q);

   odc_debounce u_debounce (
      .clk_i        (CLK_I),
      .rst_n_i      (RST_N_I),
      .clear_i      (filter_clear),
      .tick_i       (step_live),
      .differ_i     (differ),
      .mode_clear_i (counter_mode_q),
      .limit_i      (debounce_value_q),
      .accept_o     (accept)
   );

   // Detection sequencing

   assign first_seen = (state_q == ODC_ST_FIRST) && step_live;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ODC_ST_IDLE:
            if (run)
               state_d = ODC_ST_FIRST;
         ODC_ST_FIRST:
            if (!run)
               state_d = ODC_ST_IDLE;
            else if (step_live)
               state_d = ODC_ST_TRACK;
         ODC_ST_TRACK:
            if (!run)
               state_d = ODC_ST_IDLE;
         default:
            state_d = ODC_ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         state_q <= ODC_ST_IDLE;
      else
         state_q <= state_d;
   end

   // Reported orientation; the accepted value is re-checked against the
   // live input so a result frozen by high g in the same cycle is kept.
   always_comb
   begin
      orient_d = orient_q;
      if (first_seen)
         orient_d = RAW_ORIENT_I;
      else if (accept && !OVER_RANGE_I)
         orient_d = RAW_ORIENT_I;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         orient_q <= '0;
      else
         orient_q <= orient_d;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ORIENT_O <= '0;
      else
         ORIENT_O <= orient_q;
   end

   // Change flag and interrupt source

   assign status_read = REG_REQ_I.rd && (REG_REQ_I.addr == `ODC_ADDR_STATUS);

   assign set_change = first_seen || (orient_d != orient_q);

   // A change landing in the reading cycle survives the clear
   always_comb
   begin
      if (set_change)
         change_flag_d = 1'b1;
      else if (status_read)
         change_flag_d = 1'b0;
      else
         change_flag_d = change_flag_q;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         change_flag_q <= 1'b0;
      else
         change_flag_q <= change_flag_d;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         irq_source_q <= 1'b0;
      else
         irq_source_q <= change_flag_d && IRQ_ENABLE_I;
   end

   assign ORIENT_IRQ_SOURCE_O = irq_source_q;

   // Read path; status is sampled before the read clears the flag

   always_comb
   begin
      read_value = `ODC_READ_NONE;
      case (REG_REQ_I.addr)
         `ODC_ADDR_IDENT:
            read_value = DEVICE_ID;
         `ODC_ADDR_RANGE:
            read_value[`ODC_RANGE_HI:0] = range_select_q;
         `ODC_ADDR_STATUS:
         begin
            read_value[`ODC_STAT_FLAG_BIT] = change_flag_q;
            read_value[`ODC_STAT_LOCK_BIT] = orient_q.lockout;
            read_value[`ODC_STAT_CODE_HI:`ODC_STAT_CODE_LO] = orient_q.code;
            read_value[`ODC_STAT_BACK_BIT] = orient_q.back;
         end
         `ODC_ADDR_CONFIG:
         begin
            read_value[`ODC_CFG_MODE_BIT]   = counter_mode_q;
            read_value[`ODC_CFG_ENABLE_BIT] = detect_enable_q;
         end
         `ODC_ADDR_DEBOUNCE:
            read_value = debounce_value_q;
         default:
            read_value = `ODC_READ_NONE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         REG_RDATA_O <= `ODC_READ_NONE;
      else if (REG_REQ_I.rd)
         REG_RDATA_O <= read_value;
   end
endmodule

// [hdl/odc_consts.svh]
// Constants of the orientation detect and configuration block.
// Assumes a 100 MHz clock; included by bare name by the top and step timer files.
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH
`define ODC_ADDR_IDENT       8'h0D
`define ODC_ADDR_RANGE       8'h0E
`define ODC_ADDR_STATUS      8'h10
`define ODC_ADDR_CONFIG      8'h11
`define ODC_ADDR_DEBOUNCE    8'h12
`define ODC_RANGE_RST        2'h0
`define ODC_MODE_RST         1'h1
`define ODC_ENABLE_RST       1'h0
`define ODC_DEBOUNCE_RST     8'h00
`define ODC_READ_NONE        8'h00
`define ODC_STAT_FLAG_BIT    7
`define ODC_STAT_LOCK_BIT    6
`define ODC_STAT_CODE_HI     2
`define ODC_STAT_CODE_LO     1
`define ODC_STAT_BACK_BIT    0
`define ODC_CFG_MODE_BIT     7
`define ODC_CFG_ENABLE_BIT   6
`define ODC_RANGE_HI         1
`define ODC_CLK_PERIOD_NS    10
`define ODC_STEP_BASE_NS     1250000
`define ODC_STEP_BASE_CYC \
   ((`ODC_STEP_BASE_NS + `ODC_CLK_PERIOD_NS - 1) / `ODC_CLK_PERIOD_NS)
`define ODC_RATE_FIRST_SLOW  3'h5
`define ODC_EXP_RATE5        3'h6
`define ODC_EXP_SLOWEST      3'h7
`define ODC_CAP_NORMAL       3'h4
`define ODC_CAP_LOW_POWER_LOW_NOISE_MODE         3'h6
`define ODC_CAP_HIRES        3'h1
`define ODC_CAP_LP           3'h7
`endif

// [hdl/odc_pkg.sv]
// Types shared by the orientation detect and configuration block.
// Assumes the constants header is compiled alongside.
package odc_pkg;
   typedef enum logic [1:0] {
      ODC_OS_NORMAL = 2'h0,
      ODC_OS_LOW_POWER_LOW_NOISE_MODE   = 2'h1,
      ODC_OS_HIRES  = 2'h2,
      ODC_OS_LP     = 2'h3
   } odc_osmode_type;

   typedef enum logic [1:0] {
      ODC_ST_IDLE  = 2'b00,
      ODC_ST_FIRST = 2'b01,
      ODC_ST_TRACK = 2'b11
   } odc_state_type;

   typedef struct packed {
      logic       lockout;
      logic [1:0] code;
      logic       back;
   } odc_orient_type;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } odc_reg_req_type;
endpackage

// [hdl/odc_step_timer.sv]
// Debounce time step generator: one pulse per step.
// Assumes rate and oversampling mode are steady between clears.
`timescale 1ns/1ns
`include "odc_consts.svh"
module odc_step_timer
   import odc_pkg::*;
#(
   parameter int BASE_CYC = `ODC_STEP_BASE_CYC
)
(
   input  wire logic           clk_i,
   input  wire logic           rst_n_i,
   input  wire logic           clear_i,
   input  wire logic [2:0]     rate_i,
   input  wire odc_osmode_type mode_i,
   output logic                tick_o
);
   logic [31:0] pre_q;
   logic [7:0]  mul_q;
   logic [2:0]  nom;
   logic [2:0]  cap;
   logic [2:0]  expo;
   logic [7:0]  limit;
   logic        base_tick;

   always_comb
   begin
      nom = (rate_i < `ODC_RATE_FIRST_SLOW) ? rate_i :
            (rate_i == `ODC_RATE_FIRST_SLOW) ? `ODC_EXP_RATE5 :
            `ODC_EXP_SLOWEST;
      case (mode_i)
         ODC_OS_NORMAL: cap = `ODC_CAP_NORMAL;
         ODC_OS_LOW_POWER_LOW_NOISE_MODE:   cap = `ODC_CAP_LOW_POWER_LOW_NOISE_MODE;
         ODC_OS_HIRES:  cap = `ODC_CAP_HIRES;
         default:       cap = `ODC_CAP_LP;
      endcase
      expo  = (nom > cap) ? cap : nom;
      limit = 8'(8'h01 << expo) - 8'h01;
   end

   assign base_tick = (pre_q == 32'(BASE_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_q  <= 32'h0;
         mul_q  <= 8'h00;
         tick_o <= 1'b0;
      end
      else if (clear_i)
      begin
         pre_q  <= 32'h0;
         mul_q  <= 8'h00;
         tick_o <= 1'b0;
      end
      else
      begin
         pre_q  <= base_tick ? 32'h0 : pre_q + 32'h1;
         tick_o <= base_tick && (mul_q >= limit);
         if (base_tick)
            mul_q <= (mul_q >= limit) ? 8'h00 : mul_q + 8'h01;
      end
   end
endmodule

// [hdl/odc_debounce.sv]
// Orientation debounce counter, advanced once per time step.
// Assumes differ_i compares the candidate against the reported result.
`timescale 1ns/1ns
module odc_debounce
   import odc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   input  wire logic       differ_i,
   input  wire logic       mode_clear_i,
   input  wire logic [7:0] limit_i,
   output logic            accept_o
);
   logic [7:0] cnt_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q    <= 8'h00;
         accept_o <= 1'b0;
      end
      else if (clear_i)
      begin
         cnt_q    <= 8'h00;
         accept_o <= 1'b0;
      end
      else
      begin
         accept_o <= tick_i && differ_i && (cnt_q >= limit_i);
         if (tick_i)
         begin
            if (differ_i)
               cnt_q <= (cnt_q >= limit_i) ? 8'h00 : cnt_q + 8'h01;
            else if (mode_clear_i)
               cnt_q <= 8'h00;
            else if (cnt_q != 8'h00)
               cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule

// [verification/odc_props.sv]
// Checker for the orientation block, seen only through its top ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
module odc_props
   import odc_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'hA7
)
(
   input wire logic            CLK_I,
   input wire logic            RST_N_I,
   input wire odc_reg_req_type REG_REQ_I,
   input wire logic [7:0]      REG_RDATA_O,
   input wire logic            OVER_RANGE_I,
   input wire logic            IRQ_ENABLE_I,
   input wire logic [1:0]      RANGE_SELECT_O,
   input wire odc_orient_type  ORIENT_O,
   input wire logic            ORIENT_IRQ_SOURCE_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   logic       rd;
   logic [7:0] ad;
   assign rd = REG_REQ_I.rd;
   assign ad = REG_REQ_I.addr;

   a_ident_fixed: assert property (rd && ad == 8'h0D |=>
      REG_RDATA_O == DEVICE_ID) else $error("identity read wrong");
   a_range_unused: assert property (rd && ad == 8'h0E |=>
      REG_RDATA_O[7:2] == 6'h00) else $error("range spare bits set");
   a_status_unused: assert property (rd && ad == 8'h10 |=>
      REG_RDATA_O[5:3] == 3'h0) else $error("status spare bits set");
   a_config_unused: assert property (rd && ad == 8'h11 |=>
      REG_RDATA_O[5:0] == 6'h00) else $error("config spare bits set");
   a_unmapped_zero: assert property (rd &&
      !(ad inside {8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12}) |=>
      REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
   a_range_follows: assert property (REG_REQ_I.wr && ad == 8'h0E
      |=> ##1 RANGE_SELECT_O == $past(REG_REQ_I.wdata[1:0], 2))
      else $error("range output not following write");
   a_irq_needs_en: assert property (!IRQ_ENABLE_I |=>
      !ORIENT_IRQ_SOURCE_O) else $error("interrupt while disabled");
   a_frozen_orient: assert property (OVER_RANGE_I [*4] |->
      $stable(ORIENT_O)) else $error("orientation moved over range");

   c_status_flag: cover property (rd && ad == 8'h10 ##1 REG_RDATA_O[7]);
   c_irq_seen: cover property ($rose(ORIENT_IRQ_SOURCE_O));
   c_over_end: cover property (OVER_RANGE_I ##1 !OVER_RANGE_I);
endmodule

bind odc_top odc_props #(.DEVICE_ID(DEVICE_ID)) u_props (
   .CLK_I               (CLK_I),
   .RST_N_I             (RST_N_I),
   .REG_REQ_I           (REG_REQ_I),
   .REG_RDATA_O         (REG_RDATA_O),
   .OVER_RANGE_I        (OVER_RANGE_I),
   .IRQ_ENABLE_I        (IRQ_ENABLE_I),
   .RANGE_SELECT_O      (RANGE_SELECT_O),
   .ORIENT_O            (ORIENT_O),
   .ORIENT_IRQ_SOURCE_O (ORIENT_IRQ_SOURCE_O)
);

// [verification/odc_host_model.sv]
// Host side register master for the orientation block.
// Assumes one-cycle strobes sampled on the rising clock edge.
`timescale 1ns/1ns
module odc_host_model
   import odc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output odc_reg_req_type req_o
);
   initial req_o = '0;

   // Idle address and data carry the inverse so stale values never match
   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [7:0] q);
      @(posedge clk_i);
      req_o <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge clk_i);
      req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1 q = rdata_i;
   endtask
endmodule

// [verification/test_orientation_detect_config.sv]
// Self-checking bench for the orientation detect and range block.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ns
module test_orientation_detect_config;
   import odc_pkg::*;
   // Arbitrary identity value
   localparam logic [7:0] ID   = 8'h3C;
   localparam int         BASE = 4;

   logic            clk = 1'b0;
   logic            rst_n = 1'b0;
   odc_reg_req_type req;
   logic [7:0]      rdata;
   odc_orient_type  raw = '0;
   logic            over = 1'b0;
   logic            active = 1'b0;
   logic            sleep = 1'b0;
   logic [2:0]      rate = 3'h0;
   odc_osmode_type  osm = ODC_OS_NORMAL;
   logic            irq_en = 1'b1;
   logic [1:0]      rsel;
   odc_orient_type  orient;
   logic            irqs;
   int              miscompares = 0;
   int              total_checks = 0;

   always #5 clk = ~clk;

   odc_host_model host (.clk_i(clk), .rdata_i(rdata), .req_o(req));

   odc_top #(.DEVICE_ID(ID), .STEP_BASE_CYC(BASE)) dut (
      .CLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req),
      .REG_RDATA_O(rdata), .RAW_ORIENT_I(raw), .OVER_RANGE_I(over),
      .ACTIVE_I(active), .SLEEP_I(sleep), .RATE_SEL_I(rate),
      .OS_MODE_I(osm), .IRQ_ENABLE_I(irq_en), .RANGE_SELECT_O(rsel),
      .ORIENT_O(orient), .ORIENT_IRQ_SOURCE_O(irqs));

   task automatic chk8(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      host.access(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, e);
      logic [7:0] q;
      host.access(1'b0, a, 8'h00, q);
      chk8(q, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic setr(input logic [3:0] v);
      @(posedge clk);
      raw <= odc_orient_type'(v);
   endtask
   function automatic logic [7:0] st(input logic f, input logic [3:0] v);
      return {f, v[3], 3'h0, v[2:0]};
   endfunction

   task automatic t_reset;
      rchk(8'h0D, ID);
      rchk(8'h0E, 8'h00);
      rchk(8'h10, 8'h00);
      rchk(8'h11, 8'h80);
      rchk(8'h12, 8'h00);
      rchk(8'h0F, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_regs;
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h0E, 8'hFC | 8'(i));
         cyc(2);
         chk8({6'h00, rsel}, 8'(i));
         rchk(8'h0E, 8'(i));
      end
      wr(8'h0D, 8'h00);
      rchk(8'h0D, ID);
      wr(8'h10, 8'hFF);
      rchk(8'h10, 8'h00);
      wr(8'h11, 8'h3F);
      rchk(8'h11, 8'h00);
      wr(8'h12, 8'hA5);
      rchk(8'h12, 8'hA5);
      $display("test registers done");
   endtask

   task automatic t_first;
      setr(4'h7);
      wr(8'h12, 8'h00);
      wr(8'h11, 8'hC0);
      @(posedge clk);
      active <= 1'b1;
      cyc(20);
      chk8({7'h00, irqs}, 8'h01);
      chk8({4'h0, orient}, 8'h07);
      rchk(8'h10, 8'h87);
      chk8({7'h00, irqs}, 8'h00);
      rchk(8'h10, 8'h07);
      $display("test first detection done");
   endtask

   task automatic t_codes;
      logic [3:0] o;
      setr(4'h0);
      cyc(20);
      setr(4'h9);
      cyc(20);
      rchk(8'h10, st(1'b1, 4'h9));
      for (int k = 0; k < 8; k++)
      begin
         o = 4'(k * 5 + 3);
         @(posedge clk);
         irq_en <= k[0];
         setr(o);
         cyc(20);
         chk8({7'h00, irqs}, {7'h00, k[0]});
         rchk(8'h10, st(1'b1, o));
      end
      @(posedge clk);
      irq_en <= 1'b1;
      $display("test codes done");
   endtask

   task automatic t_freeze;
      @(posedge clk);
      over <= 1'b1;
      setr(4'h9);
      cyc(40);
      rchk(8'h10, st(1'b0, 4'h6));
      @(posedge clk);
      over <= 1'b0;
      cyc(20);
      rchk(8'h10, st(1'b1, 4'h9));
      wr(8'h11, 8'h80);
      setr(4'h2);
      cyc(40);
      rchk(8'h10, st(1'b0, 4'h9));
      wr(8'h11, 8'hC0);
      cyc(20);
      rchk(8'h10, st(1'b1, 4'h2));
      $display("test freeze and enable done");
   endtask

   task automatic t_debounce;
      // Four steps of four cycles are needed with a count of three
      wr(8'h12, 8'h03);
      setr(4'h5);
      cyc(6);
      rchk(8'h10, st(1'b0, 4'h2));
      cyc(24);
      rchk(8'h10, st(1'b1, 4'h5));
      setr(4'hA);
      cyc(10);
      setr(4'h5);
      cyc(6);
      setr(4'hA);
      cyc(10);
      rchk(8'h10, st(1'b0, 4'h5));
      setr(4'h5);
      cyc(10);
      setr(4'hC);
      cyc(10);
      @(posedge clk);
      sleep <= 1'b1;
      cyc(8);
      rchk(8'h10, st(1'b0, 4'h5));
      cyc(30);
      rchk(8'h10, st(1'b1, 4'hC));
      // Mode 0: one matching step only takes one count back
      wr(8'h11, 8'h40);
      @(posedge clk);
      sleep <= 1'b0;
      raw <= odc_orient_type'(4'h3);
      cyc(10);
      setr(4'hC);
      cyc(4);
      setr(4'h3);
      cyc(10);
      rchk(8'h10, st(1'b1, 4'h3));
      $display("test debounce done");
   endtask

   task automatic t_rate;
      logic [2:0]     rt[6] = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h7, 3'h3};
      odc_osmode_type md[6] = '{ODC_OS_NORMAL, ODC_OS_NORMAL, ODC_OS_HIRES,
                                ODC_OS_LOW_POWER_LOW_NOISE_MODE, ODC_OS_LP, ODC_OS_LP};
      int             ex[6] = '{1, 4, 1, 6, 7, 3};
      int             n;
      logic [3:0]     o;
      logic [3:0]     prev;
      wr(8'h12, 8'h00);
      prev = 4'h3;
      for (int i = 0; i < 6; i++)
      begin
         n = BASE << ex[i];
         o = i[0] ? 4'h3 : 4'h4;
         // Sleep toggle restarts the step timer so the phase is known
         @(posedge clk);
         rate <= rt[i];
         osm <= md[i];
         sleep <= ~sleep;
         raw <= odc_orient_type'(o);
         cyc(n / 2);
         rchk(8'h10, st(1'b0, prev));
         cyc(n);
         rchk(8'h10, st(1'b1, o));
         prev = o;
      end
      $display("test step rates done");
   endtask

   task automatic give_verdict;
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_first();
      t_codes();
      t_freeze();
      t_debounce();
      t_rate();
      give_verdict();
   end

   // The tests need about 2000 cycles; allow twenty times that
   initial
   begin
      #400000;
      miscompares++;
      give_verdict();
   end
endmodule
